// *** rtl/diag_defines.vh ***
/*
  Constants for the diagnostic event manager: event codes, class
  encodings, fail-safe output values and identification string sizes.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef DIAG_DEFINES_VH
`define DIAG_DEFINES_VH

// ****************************************************************
// event sources (bit positions of the fault vector)
// ****************************************************************
`define EV_COUNT 15
`define EV_COIL 0
`define EV_TEMP_CIRC 1
`define EV_HW 2
`define EV_MEM 3
`define EV_OVL_ONE 4
`define EV_OVL_TWO 5
`define EV_SIM 6
`define EV_OVERRIDE 7
`define EV_I1_RANGE 8
`define EV_U1_RANGE 9
`define EV_P1_RANGE 10
`define EV_I2_RANGE 11
`define EV_U2_RANGE 12
`define EV_EMPTY 13
`define EV_TEMP_RANGE 14

// ****************************************************************
// event codes (decimal values carried in 10 bits)
// ****************************************************************
`define CODE_W 10
`define CODE_COIL 10'h0_0B5
`define CODE_TEMP_CIRC 10'h0_0B4
`define CODE_HW 10'h0_0C9
`define CODE_MEM 10'h1_1B
`define CODE_OVL_ONE 10'h1_BE
`define CODE_OVL_TWO 10'h1_BF
`define CODE_SIM 10'h1_E5
`define CODE_OVERRIDE 10'h1_C5
`define CODE_I1_RANGE 10'h1_B9
`define CODE_U1_RANGE 10'h1_BC
`define CODE_P1_RANGE 10'h1_BB
`define CODE_I2_RANGE 10'h1_BA
`define CODE_U2_RANGE 10'h1_BD
`define CODE_EMPTY 10'h3_C2
`define CODE_TEMP_RANGE 10'h3_42

// ****************************************************************
// classes
// ****************************************************************
`define CLASS_W 2
`define CLASS_NONE 2'h0
`define CLASS_ALARM 2'h1
`define CLASS_CHECK 2'h2
`define CLASS_WARN 2'h3

// ****************************************************************
// fail-safe setpoints (current in uA, voltage in mV)
// ****************************************************************
`define SETPT_W 16
`define ALARM_CURRENT_UA 16'h0_DAC
`define ALARM_VOLTAGE_MV 16'h0_6D6

// ****************************************************************
// identification strings
// ****************************************************************
`define TAG_CHARS 32
`define SERIAL_CHARS 11
`define FW_CHARS 8
`define ASCII_DOT 8'h2E
`define ASCII_ZERO 8'h30
`define ASCII_HEX_ALPHA 8'h37
`define DISPLAY_PERIOD 24'h98_9680

`endif

// *** rtl/diag_priority.v ***
/*
  Priority picker: returns the lowest set index of a request vector.
  Assumes the caller orders requests so that bit 0 is most urgent.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_priority #(
  parameter N = 15,
  parameter IW = 4
) (
  input wire [N-1:0] req,
  output reg [IW-1:0] idx,
  output wire any
);
  integer i;
  assign any = |req;
  always @* begin
    idx = {IW{1'b0}};
    // scan downwards so the lowest set bit is the last to land
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        idx = i[IW-1:0];
      end
    end
  end
endmodule // diag_priority
`default_nettype wire

// *** rtl/diag_event_manager.v ***
/*
  Diagnostic event manager: classifies fault sources, picks the most
  urgent for the display, drives fail-safe reactions and reports every
  new event to the IO-Link side, except changes undone while a report is busy; also holds identification strings.
  Assumes fault inputs arrive from other clock domains or pins, and
  that the IO-Link stack takes events with a valid/ready handshake.
*/
// Operation
// [RULE_01] pending fault shows alternately with the normal view on display
// [RULE_02] several pending events: display only the highest priority one
// [RULE_03] rank alarm, then function check, then warning; fixed tie order
// [RULE_04] alarm halts measurement, forces outputs and totalizers, reports
// [RULE_05] function check covers simulation, output overload, flow override
// [RULE_06] warning keeps measuring, reduced accuracy, outputs untouched
// [RULE_07] alarm turns switch output off; other classes no effect
// [RULE_08] alarm stops pulse output; other classes no effect
// [RULE_09] alarm stops totalizer; other classes no effect
// [RULE_10] alarm forces current setpoint to 3.5 mA
// [RULE_11] alarm forces voltage setpoint to 1.75 V
// [RULE_12] every event of every class is reported to the IO-Link master; code drops changes undone while a report is busy
// [RULE_13] codes 181, 180, 201 are alarm class by default
// [RULE_14] configuration checksum failure raises alarm code 283
// [RULE_15] overload on output one 446, output two 447, function check
// [RULE_16] simulation raises 485, flow override 453, function check
// [RULE_17] range limits raise warnings 441, 442, 443, 444, 445
// [RULE_18] empty pipe raises warning 962, temperature range warning 834
// [RULE_19] tag string holds at most 32 characters
// [RULE_20] serial up to 11 characters; firmware shown as xx.yy.zz
`timescale 1ns/1ps
`default_nettype none
`include "diag_defines.vh"
module diag_event_manager #(
  parameter [23:0] DISPLAY_PERIOD = `DISPLAY_PERIOD,
  parameter [7:0] FW_MAJOR = 8'h01,
  parameter [7:0] FW_MINOR = 8'h01,
  parameter [7:0] FW_PATCH = 8'h00
) (
  input wire clk,
  input wire rst_n,
  input wire [`EV_COUNT-1:0] fault_in,
  input wire [`SETPT_W-1:0] current_setpt_in,
  input wire [`SETPT_W-1:0] voltage_setpt_in,
  input wire switch_in,
  input wire pulse_in,
  input wire total_inc_in,
  input wire tag_we,
  input wire [4:0] tag_addr,
  input wire [7:0] tag_data,
  input wire serial_we,
  input wire [3:0] serial_addr,
  input wire [7:0] serial_data,
  input wire [4:0] id_addr,
  output reg [7:0] tag_char_q,
  output reg [7:0] serial_char_q,
  output reg [7:0] fw_char_q,
  output reg show_diag_q,
  output reg [`CODE_W-1:0] disp_code_q,
  output reg [`CLASS_W-1:0] disp_class_q,
  output reg measure_run_q,
  output reg reduced_accuracy_q,
  output reg switch_out_q,
  output reg pulse_out_q,
  output reg total_run_q,
  output reg [`SETPT_W-1:0] current_setpt_q,
  output reg [`SETPT_W-1:0] voltage_setpt_q,
  output wire ev_valid,
  input wire ev_ready,
  output reg [`CODE_W-1:0] ev_code_q,
  output reg [`CLASS_W-1:0] ev_class_q,
  output reg ev_appear_q,
  output reg [31:0] total_count_q
);
  // ****************************************************************
  // code and class tables
  // ****************************************************************
  function [`CODE_W-1:0] code_of;
    input [3:0] i;
    begin
      case (i)
        `EV_COIL: code_of = `CODE_COIL; // RULE_13
        `EV_TEMP_CIRC: code_of = `CODE_TEMP_CIRC; // RULE_13
        `EV_HW: code_of = `CODE_HW; // RULE_13
        `EV_MEM: code_of = `CODE_MEM; // RULE_14
        `EV_OVL_ONE: code_of = `CODE_OVL_ONE; // RULE_15
        `EV_OVL_TWO: code_of = `CODE_OVL_TWO; // RULE_15
        `EV_SIM: code_of = `CODE_SIM; // RULE_16
        `EV_OVERRIDE: code_of = `CODE_OVERRIDE; // RULE_16
        `EV_I1_RANGE: code_of = `CODE_I1_RANGE; // RULE_17
        `EV_U1_RANGE: code_of = `CODE_U1_RANGE; // RULE_17
        `EV_P1_RANGE: code_of = `CODE_P1_RANGE; // RULE_17
        `EV_I2_RANGE: code_of = `CODE_I2_RANGE; // RULE_17
        `EV_U2_RANGE: code_of = `CODE_U2_RANGE; // RULE_17
        `EV_EMPTY: code_of = `CODE_EMPTY; // RULE_18
        `EV_TEMP_RANGE: code_of = `CODE_TEMP_RANGE; // RULE_18
        default: code_of = {`CODE_W{1'b0}};
      endcase
    end
  endfunction

  // bit order already groups alarm, check, warning, so index sets rank
  function [`CLASS_W-1:0] class_of;
    input [3:0] i;
    begin
      if (i <= `EV_MEM) begin
        class_of = `CLASS_ALARM; // RULE_13 RULE_14
      end else if (i <= `EV_OVERRIDE) begin
        class_of = `CLASS_CHECK; // RULE_05
      end else if (i < `EV_COUNT) begin
        class_of = `CLASS_WARN; // RULE_06
      end else begin
        class_of = `CLASS_NONE;
      end
    end
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [`EV_COUNT-1:0] fault_m_q;
  reg [`EV_COUNT-1:0] fault_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      fault_m_q <= {`EV_COUNT{1'b0}};
      fault_q <= {`EV_COUNT{1'b0}};
    end else begin
      fault_m_q <= fault_in;
      fault_q <= fault_m_q;
    end
  end

  // ****************************************************************
  // priority selection
  // ****************************************************************
  wire [3:0] top_idx;
  wire any_pending;
  diag_priority #(.N(`EV_COUNT), .IW(4)) u_prio (
    .req(fault_q),
    .idx(top_idx),
    .any(any_pending)
  ); // RULE_02 RULE_03
  wire alarm_active = |fault_q[`EV_MEM:`EV_COIL];
  wire warn_active = |fault_q[`EV_TEMP_RANGE:`EV_I1_RANGE];

  // ****************************************************************
  // display alternation
  // ****************************************************************
  reg [23:0] alt_cnt_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      alt_cnt_q <= 24'h00_0000;
      show_diag_q <= 1'b0;
      disp_code_q <= {`CODE_W{1'b0}};
      disp_class_q <= `CLASS_NONE;
    end else begin
      disp_code_q <= any_pending ? code_of(top_idx) : {`CODE_W{1'b0}};
      disp_class_q <= any_pending ? class_of(top_idx) : `CLASS_NONE;
      if (!any_pending) begin
        alt_cnt_q <= 24'h00_0000;
        show_diag_q <= 1'b0;
      end else if (alt_cnt_q >= DISPLAY_PERIOD - 24'h00_0001) begin
        alt_cnt_q <= 24'h00_0000;
        show_diag_q <= ~show_diag_q; // RULE_01
      end else begin
        alt_cnt_q <= alt_cnt_q + 24'h00_0001;
      end
    end
  end

  // ****************************************************************
  // fail-safe reactions
  // ****************************************************************
  // checks do not reach the outputs at all; warnings only set reduced_accuracy_q
  always @(posedge clk) begin
    if (!rst_n) begin
      measure_run_q <= 1'b0;
      reduced_accuracy_q <= 1'b0;
      switch_out_q <= 1'b0;
      pulse_out_q <= 1'b0;
      total_run_q <= 1'b0;
    end else begin
      measure_run_q <= ~alarm_active; // RULE_04
      reduced_accuracy_q <= warn_active & ~alarm_active; // RULE_06
      switch_out_q <= switch_in & ~alarm_active; // RULE_07
      pulse_out_q <= pulse_in & ~alarm_active; // RULE_08
      total_run_q <= ~alarm_active; // RULE_09
    end
  end

  // ****************************************************************
  // totalizer
  // ****************************************************************
  // frozen, not cleared, so the count resumes where it stopped
  always @(posedge clk) begin
    if (!rst_n) begin
      total_count_q <= 32'h0000_0000;
    end else if (total_inc_in && !alarm_active) begin
      total_count_q <= total_count_q + 32'h0000_0001; // RULE_09
    end
  end

  // ****************************************************************
  // fail-safe setpoints
  // ****************************************************************
  // alarm values hold through reset so the loop reads fault until ready
  always @(posedge clk) begin
    if (!rst_n) begin
      current_setpt_q <= `ALARM_CURRENT_UA;
      voltage_setpt_q <= `ALARM_VOLTAGE_MV;
    end else if (alarm_active) begin
      current_setpt_q <= `ALARM_CURRENT_UA; // RULE_10
      voltage_setpt_q <= `ALARM_VOLTAGE_MV; // RULE_11
    end else begin
      current_setpt_q <= current_setpt_in; // RULE_10
      voltage_setpt_q <= voltage_setpt_in; // RULE_11
    end
  end

  // ****************************************************************
  // event reporting
  // ****************************************************************
  // one transition pending per source; a change while busy is sent later only if it still
  // differs from reported_q when the handshake ends, since reported state lags the live state
  reg [`EV_COUNT-1:0] reported_q;
  reg busy_q;
  reg [3:0] ev_idx_q;
  wire [`EV_COUNT-1:0] changed = fault_q ^ reported_q;
  wire [3:0] chg_idx;
  wire chg_any;
  diag_priority #(.N(`EV_COUNT), .IW(4)) u_chg (
    .req(changed),
    .idx(chg_idx),
    .any(chg_any)
  );
  assign ev_valid = busy_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      reported_q <= {`EV_COUNT{1'b0}};
      busy_q <= 1'b0;
      ev_idx_q <= 4'h0;
      ev_code_q <= {`CODE_W{1'b0}};
      ev_class_q <= `CLASS_NONE;
      ev_appear_q <= 1'b0;
    end else if (busy_q) begin
      if (ev_ready) begin
        busy_q <= 1'b0;
        reported_q[ev_idx_q] <= ev_appear_q; // RULE_12
      end
    end else if (chg_any) begin
      busy_q <= 1'b1; // RULE_12
      ev_idx_q <= chg_idx;
      ev_code_q <= code_of(chg_idx);
      ev_class_q <= class_of(chg_idx);
      ev_appear_q <= fault_q[chg_idx];
    end
  end

  // ****************************************************************
  // identification strings
  // ****************************************************************
  reg [7:0] tag_mem [0:`TAG_CHARS-1];
  reg [7:0] serial_mem [0:`SERIAL_CHARS-1];
  always @(posedge clk) begin
    if (tag_we) begin
      tag_mem[tag_addr] <= tag_data; // RULE_19
    end
    if (serial_we && serial_addr < `SERIAL_CHARS) begin
      serial_mem[serial_addr] <= serial_data; // RULE_20
    end
  end

  // digits above nine show as capital letters
  function [7:0] hex_char;
    input [3:0] n;
    begin
      if (n > 4'h9) begin
        hex_char = `ASCII_HEX_ALPHA + {4'h0, n};
      end else begin
        hex_char = `ASCII_ZERO + {4'h0, n};
      end
    end
  endfunction

  always @(posedge clk) begin
    if (!rst_n) begin
      tag_char_q <= 8'h00;
      serial_char_q <= 8'h00;
      fw_char_q <= 8'h00;
    end else begin
      tag_char_q <= tag_mem[id_addr];
      serial_char_q <= (id_addr < `SERIAL_CHARS) ?
        serial_mem[id_addr[3:0]] : 8'h00;
      case (id_addr)
        5'h00: fw_char_q <= hex_char(FW_MAJOR[7:4]); // RULE_20
        5'h01: fw_char_q <= hex_char(FW_MAJOR[3:0]);
        5'h02: fw_char_q <= `ASCII_DOT;
        5'h03: fw_char_q <= hex_char(FW_MINOR[7:4]);
        5'h04: fw_char_q <= hex_char(FW_MINOR[3:0]);
        5'h05: fw_char_q <= `ASCII_DOT;
        5'h06: fw_char_q <= hex_char(FW_PATCH[7:4]);
        5'h07: fw_char_q <= hex_char(FW_PATCH[3:0]);
        default: fw_char_q <= 8'h00;
      endcase
    end
  end
endmodule // diag_event_manager
`default_nettype wire

// *** tb/diag_event_monitor.sv ***
/* port checker for the event manager, bound to every instance.
   assumes DISPLAY_PERIOD is set to 4 in simulation. */
`timescale 1ns/1ps
`default_nettype none
`include "diag_defines.vh"
module diag_event_monitor (
  input wire clk,
  input wire rst_n,
  input wire show_diag_q,
  input wire [`CODE_W-1:0] disp_code_q,
  input wire [`CLASS_W-1:0] disp_class_q,
  input wire measure_run_q,
  input wire reduced_accuracy_q,
  input wire switch_out_q,
  input wire pulse_out_q,
  input wire total_run_q,
  input wire [`SETPT_W-1:0] current_setpt_q,
  input wire [`SETPT_W-1:0] voltage_setpt_q,
  input wire ev_valid,
  input wire ev_ready,
  input wire [`CODE_W-1:0] ev_code_q,
  input wire [`CLASS_W-1:0] ev_class_q,
  input wire [31:0] total_count_q
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire alarm = disp_class_q == `CLASS_ALARM;
  wire busy = disp_class_q != `CLASS_NONE;
  property p_alarm_out;
    alarm |-> !switch_out_q && !pulse_out_q && !total_run_q && !measure_run_q;
  endproperty
  a_alarm_out: assert property (p_alarm_out)
    else $error("output live in alarm");
  property p_alarm_setpt;
    alarm |-> current_setpt_q == 16'h0DAC && voltage_setpt_q == 16'h06D6;
  endproperty
  a_alarm_setpt: assert property (p_alarm_setpt)
    else $error("setpoint not forced in alarm");
  property p_warn_run;
    disp_class_q == `CLASS_WARN |-> measure_run_q && reduced_accuracy_q;
  endproperty
  a_warn_run: assert property (p_warn_run)
    else $error("warning stopped measuring");
  property p_freeze;
    $past(alarm) && alarm |-> $stable(total_count_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("totalizer moved in alarm");
  property p_dark;
    !busy ##1 !busy |-> !show_diag_q;
  endproperty
  a_dark: assert property (p_dark)
    else $error("diagnostic view with nothing pending");
  property p_blink;
    busy && !show_diag_q |-> ##[1:8] (show_diag_q || !busy);
  endproperty
  a_blink: assert property (p_blink)
    else $error("diagnostic view never shown");
  property p_show_hold;
    $rose(show_diag_q) |=> (show_diag_q || !busy)[*3];
  endproperty
  a_show_hold: assert property (p_show_hold)
    else $error("diagnostic view too short");
  property p_hold;
    ev_valid && !ev_ready |=> ev_valid && $stable({ev_code_q, ev_class_q});
  endproperty
  a_hold: assert property (p_hold)
    else $error("event withdrawn before taken");
  property p_gap;
    ev_valid && ev_ready |=> !ev_valid;
  endproperty
  a_gap: assert property (p_gap)
    else $error("event offered right after handshake");
  property p_alarm_codes;
    alarm |-> disp_code_q inside {10'h0B5, 10'h0B4, 10'h0C9, 10'h11B};
  endproperty
  a_alarm_codes: assert property (p_alarm_codes)
    else $error("alarm class on wrong code");
  c_alarm: cover property (alarm);
  c_take: cover property (ev_valid && ev_ready);
  c_show: cover property ($rose(show_diag_q));
endmodule // diag_event_monitor
bind diag_event_manager diag_event_monitor mon_u (.clk(clk), .rst_n(rst_n),
  .show_diag_q(show_diag_q), .disp_code_q(disp_code_q),
  .disp_class_q(disp_class_q), .measure_run_q(measure_run_q),
  .reduced_accuracy_q(reduced_accuracy_q), .switch_out_q(switch_out_q),
  .pulse_out_q(pulse_out_q), .total_run_q(total_run_q),
  .current_setpt_q(current_setpt_q), .voltage_setpt_q(voltage_setpt_q),
  .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_code_q(ev_code_q),
  .ev_class_q(ev_class_q), .total_count_q(total_count_q));
`default_nettype wire

// *** tb/iolink_master_model.sv ***
/* event taker on the far side: logs every accepted event.
   assumes the bench raises stall to make it slow. */
`timescale 1ns/1ps
`default_nettype none
module iolink_master_model (
  input wire clk,
  input wire rst_n,
  input wire stall,
  input wire ev_valid,
  input wire [9:0] ev_code_q,
  input wire [1:0] ev_class_q,
  input wire ev_appear_q,
  output logic ev_ready
);
  // ********
  // accept and log
  // ********
  logic [12:0] log_q[$];
  always @(posedge clk) begin
    if (!rst_n) begin
      ev_ready <= 1'b0;
      log_q.delete();
    end else begin
      if (ev_valid && ev_ready) begin
        log_q.push_back({ev_appear_q, ev_class_q, ev_code_q});
      end
      ev_ready <= !stall;
    end
  end
endmodule // iolink_master_model
`default_nettype wire

// *** tb/diag_event_manager_tb.sv ***
/* self-checking bench for the event manager.
   assumes the master model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module diag_event_manager_tb;
  logic clk = 0, rst_n = 0, stall = 0, tag_we = 0, serial_we = 0;
  logic [14:0] fault_in = 0;
  logic switch_in = 1, pulse_in = 1, total_inc_in = 1;
  logic [15:0] current_setpt_in = 16'h1F40, voltage_setpt_in = 16'h0FA0;
  logic [4:0] tag_addr = 0, id_addr = 0;
  logic [3:0] serial_addr = 0;
  logic [7:0] tag_data = 0, serial_data = 0;
  wire ev_valid, ev_ready, ev_appear_q, show_diag_q;
  wire [9:0] ev_code_q, disp_code_q;
  wire [1:0] ev_class_q, disp_class_q;
  wire [7:0] tag_char_q, serial_char_q, fw_char_q;
  wire measure_run_q, reduced_accuracy_q, switch_out_q, pulse_out_q;
  wire total_run_q;
  wire [15:0] current_setpt_q, voltage_setpt_q;
  wire [31:0] total_count_q;
  int bad_count = 0, n_tests = 0;
  logic [9:0] code_t [15] = '{10'h0B5, 10'h0B4, 10'h0C9, 10'h11B, 10'h1BE,
    10'h1BF, 10'h1E5, 10'h1C5, 10'h1B9, 10'h1BC, 10'h1BB, 10'h1BA, 10'h1BD,
    10'h3C2, 10'h342};
  diag_event_manager #(.DISPLAY_PERIOD(24'h00_0004), .FW_MAJOR(8'h12),
    .FW_MINOR(8'h34), .FW_PATCH(8'h56)) dut_u (.clk(clk), .rst_n(rst_n),
    .fault_in(fault_in), .current_setpt_in(current_setpt_in),
    .voltage_setpt_in(voltage_setpt_in), .switch_in(switch_in),
    .pulse_in(pulse_in), .total_inc_in(total_inc_in), .tag_we(tag_we),
    .tag_addr(tag_addr),
    .tag_data(tag_data), .serial_we(serial_we), .serial_addr(serial_addr),
    .serial_data(serial_data), .id_addr(id_addr), .tag_char_q(tag_char_q),
    .serial_char_q(serial_char_q), .fw_char_q(fw_char_q),
    .show_diag_q(show_diag_q), .disp_code_q(disp_code_q),
    .disp_class_q(disp_class_q), .measure_run_q(measure_run_q),
    .reduced_accuracy_q(reduced_accuracy_q), .switch_out_q(switch_out_q),
    .pulse_out_q(pulse_out_q), .total_run_q(total_run_q),
    .current_setpt_q(current_setpt_q), .voltage_setpt_q(voltage_setpt_q),
    .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_code_q(ev_code_q),
    .ev_class_q(ev_class_q), .ev_appear_q(ev_appear_q),
    .total_count_q(total_count_q));
  iolink_master_model partner_u (.clk(clk), .rst_n(rst_n), .stall(stall),
    .ev_valid(ev_valid), .ev_code_q(ev_code_q), .ev_class_q(ev_class_q),
    .ev_appear_q(ev_appear_q), .ev_ready(ev_ready));
  // ********
  // helpers
  // ********
  initial forever #2 clk = ~clk;
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [12:0] pop();
    if (partner_u.log_q.size() == 0) return 13'h1FFF;
    return partner_u.log_q.pop_front();
  endfunction
  task set_f(input logic [14:0] v);
    @(negedge clk) fault_in = v;
    repeat (8) @(negedge clk);
  endtask
  task rd(input logic [4:0] a);
    @(negedge clk) id_addr = a;
    @(negedge clk);
  endtask
  // ********
  // scenarios
  // ********
  task t_each;
    logic [1:0] c;
    logic a;
    logic [31:0] t0;
    for (int i = 0; i < 15; i++) begin
      c = i < 4 ? 2'h1 : (i < 8 ? 2'h2 : 2'h3);
      a = c == 2'h1;
      set_f(15'h0001 << i);
      chk("code", disp_code_q, code_t[i]);
      chk("class", disp_class_q, c);
      chk("switch", switch_out_q, !a);
      chk("pulse", pulse_out_q, !a);
      chk("cur", current_setpt_q, a ? 16'h0DAC : 16'h1F40);
      chk("volt", voltage_setpt_q, a ? 16'h06D6 : 16'h0FA0);
      chk("measure", measure_run_q, !a);
      chk("total run", total_run_q, !a);
      chk("reduced", reduced_accuracy_q, c == 2'h3);
      t0 = total_count_q;
      @(negedge clk);
      chk("count", total_count_q, a ? t0 : t0 + 1);
      chk("came", pop(), {1'b1, c, code_t[i]});
      set_f(15'h0000);
      chk("went", pop(), {1'b0, c, code_t[i]});
      chk("idle", disp_class_q, 2'h0);
    end
    $display("each event done");
  endtask
  task t_prio;
    logic [1:0] c;
    set_f(15'h402C);
    // four reports at two edges each outlast the settle time
    repeat (4) @(negedge clk);
    chk("top", disp_code_q, 10'h0C9);
    foreach (code_t[i]) if (i == 2 || i == 3 || i == 5 || i == 14) begin
      c = i < 4 ? 2'h1 : (i == 5 ? 2'h2 : 2'h3);
      chk("order", pop(), {1'b1, c, code_t[i]});
    end
    current_setpt_in = 16'h2EE0;
    voltage_setpt_in = 16'h0BB8;
    set_f(15'h4020);
    chk("check top", disp_code_q, 10'h1BF);
    chk("check switch", switch_out_q, 1'b1);
    chk("check cur", current_setpt_q, 16'h2EE0);
    chk("check volt", voltage_setpt_q, 16'h0BB8);
    current_setpt_in = 16'h1F40;
    voltage_setpt_in = 16'h0FA0;
    set_f(15'h4000);
    chk("warn top", disp_code_q, 10'h342);
    set_f(15'h0000);
    partner_u.log_q.delete();
    $display("priority done");
  endtask
  task t_blink;
    int n;
    logic p;
    set_f(15'h2000);
    n = 0;
    p = show_diag_q;
    repeat (16) begin
      @(negedge clk);
      n += show_diag_q !== p;
      p = show_diag_q;
    end
    chk("toggles", n, 4);
    set_f(15'h0000);
    chk("view off", show_diag_q, 1'b0);
    partner_u.log_q.delete();
    $display("blink done");
  endtask
  task t_stall;
    stall = 1;
    set_f(15'h0201);
    repeat (4) @(negedge clk);
    chk("held", {ev_valid, ev_code_q}, {1'b1, 10'h0B5});
    stall = 0;
    set_f(15'h0000);
    chk("first", pop(), {3'h5, 10'h0B5});
    chk("second", pop(), {3'h7, 10'h1BC});
    partner_u.log_q.delete();
    $display("stall done");
  endtask
  task t_id;
    @(negedge clk);
    {tag_we, tag_addr, tag_data} = {1'b1, 5'h1F, 8'h40};
    {serial_we, serial_addr, serial_data} = {1'b1, 4'hA, 8'h5A};
    @(negedge clk);
    {tag_we, serial_we} = 2'h0;
    rd(5'h1F);
    chk("tag", tag_char_q, 8'h40);
    rd(5'h0A);
    chk("serial", serial_char_q, 8'h5A);
    rd(5'h0B);
    chk("serial end", serial_char_q, 8'h00);
    rd(5'h02);
    chk("fw dot", fw_char_q, 8'h2E);
    rd(5'h07);
    chk("fw last", fw_char_q, 8'h36);
    $display("identity done");
  endtask
  // ********
  // run
  // ********
  task complete_run;
    $display("tests %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    chk("reset cur", current_setpt_q, 16'h0DAC);
    rst_n = 1;
    t_each();
    t_prio();
    t_blink();
    t_stall();
    t_id();
    complete_run();
  end
  initial begin
    #40000;
    bad_count++;
    complete_run();
  end
endmodule // diag_event_manager_tb
`default_nettype wire
